// [utxpc_pkg.sv]
package utxpc_pkg;
    // -----------------------------------------------------------------
    // register offsets on the 8-bit microprocessor port
    // -----------------------------------------------------------------
    localparam logic [7:0] UTXPC_OFF_CTRL2 = 8'h01; // cell processor enable
    localparam logic [7:0] UTXPC_OFF_CTRL0 = 8'h03; // parity options
    localparam logic [7:0] UTXPC_OFF_ISTAT = 8'h0B; // interrupt status
    localparam logic [7:0] UTXPC_OFF_IENA = 8'h0F; // interrupt enable
    localparam logic [7:0] UTXPC_OFF_CNT3 = 8'h34; // count bits 31:24
    localparam logic [7:0] UTXPC_OFF_CNT2 = 8'h35; // count bits 23:16
    localparam logic [7:0] UTXPC_OFF_CNT1 = 8'h36; // count bits 15:8
    localparam logic [7:0] UTXPC_OFF_CNT0 = 8'h37; // count bits 7:0
    // -----------------------------------------------------------------
    // field positions
    // -----------------------------------------------------------------
    localparam int UTXPC_B_PROC_EN = 0; // control byte 2
    localparam int UTXPC_B_PAR_EN = 5; // control byte 0
    localparam int UTXPC_B_DISCARD = 4; // control byte 0
    localparam int UTXPC_B_ODD = 3; // control byte 0
    localparam int UTXPC_B_PAR_IRQ = 0; // status and enable
    // writable bits of control byte 0 (bits 2:1 read-only zero)
    localparam logic [7:0] UTXPC_CTRL0_WMASK = 8'hF9;
    // -----------------------------------------------------------------
    // reset values
    // -----------------------------------------------------------------
    localparam logic UTXPC_RST_PROC_EN = 1'b1;
    localparam logic [7:0] UTXPC_RST_CTRL0 = 8'h28;
    localparam logic UTXPC_RST_IENA = 1'b1;
    // -----------------------------------------------------------------
    // cell lengths in transfers
    // -----------------------------------------------------------------
    localparam logic [5:0] UTXPC_CELL_BYTES = 6'h35; // 8-bit bus, 53
    localparam logic [5:0] UTXPC_CELL_WORDS = 6'h1B; // 16-bit bus, 27
    localparam logic [31:0] UTXPC_CNT_MAX = 32'hFFFFFFFF;
    // checker states
    typedef enum logic [1:0] {
        UTXPC_IDLE,
        UTXPC_CHECK,
        UTXPC_SEND_RD,
        UTXPC_SEND_HOLD
    } utxpc_state_t;
endpackage

// [utxpc_mem.sv]
module utxpc_mem #(
    parameter int W = 17,
    parameter int DEPTH = 128
) (
    input wire logic sys_clk_i,
    input wire logic wr_en_i,
    input wire logic [$clog2(DEPTH)-1:0] wr_addr_i,
    input wire logic [W-1:0] wr_data_i,
    input wire logic [$clog2(DEPTH)-1:0] rd_addr_i,
    output logic [W-1:0] rd_data_o
);
    // -----------------------------------------------------------------
    // storage
    // -----------------------------------------------------------------
    logic [W-1:0] mem [DEPTH]; // word plus parity bit
    logic [W-1:0] rd_data_ff; // registered read data

    // no reset on the array: contents are only read after being written
    always_ff @(posedge sys_clk_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
        rd_data_ff <= mem[rd_addr_i];
    end

    assign rd_data_o = rd_data_ff;
endmodule

// [utxpc_checker.sv]
// How it works
// - data taken on link clock rising edge
// - parity stored with word in FIFO
// - recompute parity on FIFO readout, compare
// - good word: continue with next word
// - each mismatched word raises an error event
// - enable bit gates all parity checking
// - sense bit selects odd or even
// - disabled check ignores sense and discard
// - discard bit drops errored cells whole
// - discard clear forwards errored cells, reports
// - sticky status bit, masked active-low interrupt
// - saturating 32-bit counter, reset on read
// - no fifo writes or new cell readout unless processor enable set
module utxpc_checker #(
    parameter int DEPTH = 128
) (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // link side, asynchronous to sys_clk_i
    input wire logic tx_interface_clock_i,
    input wire logic [15:0] tx_cell_data_bus_i,
    input wire logic tx_word_parity_in_i,
    input wire logic tx_write_enable_b_i,
    input wire logic tx_bus16_mode_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic irq_b_o,
    // downstream cell stream
    output logic cell_valid_o,
    output logic [15:0] cell_data_o,
    output logic cell_last_o,
    input wire logic cell_ready_i,
    output logic fifo_overflow_o
);
    import utxpc_pkg::*;

    localparam int AW = $clog2(DEPTH);

    // pointers wrap on a power of two and one whole cell must fit
    if (DEPTH < 64 || (1 << AW) != DEPTH) begin : g_depth_bad
        $error("utxpc_checker: DEPTH must be a power of two >= 64");
    end

    // -----------------------------------------------------------------
    // parity decode, used on each word read back in the check pass
    // -----------------------------------------------------------------
    function automatic logic par_bad(input logic [16:0] w, input logic b16,
                                     input logic odd);
        logic ones;
        ones = (b16 ? ^w[15:0] : ^w[7:0]) ^ w[16];
        par_bad = (ones != odd);
    endfunction

    // -----------------------------------------------------------------
    // link input synchronisers
    // -----------------------------------------------------------------
    logic [19:0] sync1_ff, sync2_ff; // clk, we_b, b16, parity, data
    logic lclk_d_ff; // previous synchronised link clock
    always_ff @(posedge sys_clk_i) begin
        sync1_ff <= {tx_interface_clock_i, tx_write_enable_b_i,
                     tx_bus16_mode_i, tx_word_parity_in_i,
                     tx_cell_data_bus_i};
        sync2_ff <= sync1_ff;
        lclk_d_ff <= sync2_ff[19];
    end
    logic lclk_rise; // rising edge of the link clock
    logic bus16; // 16-bit bus mode
    assign lclk_rise = sync2_ff[19] & ~lclk_d_ff;
    assign bus16 = sync2_ff[17];

    // -----------------------------------------------------------------
    // registers of the processor port
    // -----------------------------------------------------------------
    logic proc_en_ff, nxt_proc_en; // control byte 2 bit 0
    logic [7:0] ctrl0_ff, nxt_ctrl0; // control byte 0
    logic iena_ff, nxt_iena; // parity interrupt enable
    logic istat_ff, nxt_istat; // parity interrupt status
    logic [31:0] cnt_ff, nxt_cnt; // parity error count
    logic [23:0] snap_ff, nxt_snap; // low bytes held at byte 3 read
    logic [7:0] rdata_ff, nxt_rdata; // registered read data
    logic par_en, odd_sel, discard; // effective options
    logic word_err; // one parity error this cycle
    assign par_en = ctrl0_ff[UTXPC_B_PAR_EN];
    assign odd_sel = par_en & ctrl0_ff[UTXPC_B_ODD];
    assign discard = par_en & ctrl0_ff[UTXPC_B_DISCARD];

    // register next values; an error in the read cycle beats the clear
    always_comb begin
        nxt_proc_en = proc_en_ff;
        nxt_ctrl0 = ctrl0_ff;
        nxt_iena = iena_ff;
        nxt_istat = istat_ff;
        nxt_cnt = cnt_ff;
        nxt_snap = snap_ff;
        nxt_rdata = rdata_ff;
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                UTXPC_OFF_CTRL2: nxt_proc_en = reg_wdata_i[UTXPC_B_PROC_EN];
                UTXPC_OFF_CTRL0: nxt_ctrl0 = reg_wdata_i & UTXPC_CTRL0_WMASK;
                UTXPC_OFF_IENA: nxt_iena = reg_wdata_i[UTXPC_B_PAR_IRQ];
                default: ; // other offsets take no writes
            endcase
        end
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                UTXPC_OFF_CTRL2: nxt_rdata = {7'h00, proc_en_ff};
                UTXPC_OFF_CTRL0: nxt_rdata = ctrl0_ff;
                UTXPC_OFF_IENA: nxt_rdata = {7'h00, iena_ff};
                UTXPC_OFF_ISTAT: begin
                    nxt_rdata = {7'h00, istat_ff};
                    nxt_istat = 1'b0;
                end
                UTXPC_OFF_CNT3: begin
                    // reading the top byte freezes and clears the count
                    nxt_rdata = cnt_ff[31:24];
                    nxt_snap = cnt_ff[23:0];
                    nxt_cnt = 32'h00000000;
                end
                UTXPC_OFF_CNT2: nxt_rdata = snap_ff[23:16];
                UTXPC_OFF_CNT1: nxt_rdata = snap_ff[15:8];
                UTXPC_OFF_CNT0: nxt_rdata = snap_ff[7:0];
                default: nxt_rdata = 8'h00; // unmapped reads zero
            endcase
        end
        if (word_err) begin
            nxt_istat = 1'b1;
            if (nxt_cnt != UTXPC_CNT_MAX) begin
                nxt_cnt = nxt_cnt + 32'h00000001;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            proc_en_ff <= UTXPC_RST_PROC_EN;
            ctrl0_ff <= UTXPC_RST_CTRL0;
            iena_ff <= UTXPC_RST_IENA;
            istat_ff <= 1'b0;
            cnt_ff <= 32'h00000000;
            snap_ff <= 24'h000000;
            rdata_ff <= 8'h00;
        end else begin
            proc_en_ff <= nxt_proc_en;
            ctrl0_ff <= nxt_ctrl0;
            iena_ff <= nxt_iena;
            istat_ff <= nxt_istat;
            cnt_ff <= nxt_cnt;
            snap_ff <= nxt_snap;
            rdata_ff <= nxt_rdata;
        end
    end
    assign reg_rdata_o = rdata_ff;
    assign irq_b_o = ~(istat_ff & iena_ff);

    // -----------------------------------------------------------------
    // fifo write side
    // -----------------------------------------------------------------
    logic [AW:0] wr_ptr_ff, nxt_wr_ptr; // write pointer
    logic [AW:0] rd_ptr_ff, nxt_rd_ptr; // read pointer, cell start
    logic ovf_ff, nxt_ovf; // sticky overflow indication
    logic [AW:0] level; // words held
    logic wr_en; // store one word this cycle
    assign level = wr_ptr_ff - rd_ptr_ff;
    // full fifo drops the word; the source is expected to watch space
    assign wr_en = lclk_rise & ~sync2_ff[18] & proc_en_ff
                   & (level != DEPTH[AW:0]);

    always_comb begin
        nxt_wr_ptr = wr_ptr_ff;
        nxt_ovf = ovf_ff;
        if (wr_en) begin
            nxt_wr_ptr = wr_ptr_ff + 1'b1;
        end
        if (lclk_rise & ~sync2_ff[18] & (level == DEPTH[AW:0])) begin
            nxt_ovf = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            wr_ptr_ff <= '0;
            ovf_ff <= 1'b0;
        end else begin
            wr_ptr_ff <= nxt_wr_ptr;
            ovf_ff <= nxt_ovf;
        end
    end
    assign fifo_overflow_o = ovf_ff;

    // -----------------------------------------------------------------
    // readout: first pass checks the cell and drops it if discarded, second forwards it
    // -----------------------------------------------------------------
    utxpc_state_t state_ff, nxt_state;
    logic [5:0] idx_ff, nxt_idx; // word index within the cell
    logic [5:0] cell_len_ff, nxt_cell_len; // cell length in transfers
    logic b16_ff, nxt_b16; // bus mode frozen per cell
    logic chk_vld_ff, nxt_chk_vld; // read data is a word to check
    logic cell_err_ff, nxt_cell_err; // any word of this cell failed
    logic ovalid_ff, nxt_ovalid;
    logic [15:0] odata_ff, nxt_odata;
    logic olast_ff, nxt_olast;
    logic [AW-1:0] rd_addr; // memory read address
    logic [16:0] rd_word; // stored word and parity
    logic [5:0] len_now; // length for the current mode
    assign len_now = bus16 ? UTXPC_CELL_WORDS : UTXPC_CELL_BYTES;
    assign rd_addr = rd_ptr_ff[AW-1:0] + AW'(idx_ff);
    assign word_err = chk_vld_ff & par_en & par_bad(rd_word, b16_ff,
                                                    odd_sel);

    always_comb begin
        nxt_state = state_ff;
        nxt_idx = idx_ff;
        nxt_cell_len = cell_len_ff;
        nxt_b16 = b16_ff;
        nxt_chk_vld = 1'b0;
        nxt_cell_err = cell_err_ff | word_err;
        nxt_rd_ptr = rd_ptr_ff;
        nxt_ovalid = ovalid_ff;
        nxt_odata = odata_ff;
        nxt_olast = olast_ff;
        unique case (state_ff)
            UTXPC_IDLE: begin
                if (proc_en_ff && level >= {{(AW-5){1'b0}}, len_now}) begin
                    nxt_state = UTXPC_CHECK;
                    nxt_idx = 6'd0;
                    nxt_cell_len = len_now;
                    nxt_b16 = bus16;
                    nxt_cell_err = 1'b0;
                end
            end
            UTXPC_CHECK: begin
                // one word per cycle; results land a cycle later
                if (idx_ff != cell_len_ff) begin
                    nxt_chk_vld = 1'b1;
                    nxt_idx = idx_ff + 6'd1;
                end else if (!chk_vld_ff) begin
                    nxt_idx = 6'd0;
                    if (cell_err_ff && discard) begin
                        nxt_rd_ptr = rd_ptr_ff + (AW+1)'(cell_len_ff);
                        nxt_state = UTXPC_IDLE;
                    end else begin
                        nxt_state = UTXPC_SEND_RD;
                    end
                end
            end
            UTXPC_SEND_RD: begin
                nxt_state = UTXPC_SEND_HOLD; // read issued this cycle
            end
            UTXPC_SEND_HOLD: begin
                if (!ovalid_ff) begin
                    nxt_ovalid = 1'b1;
                    nxt_odata = b16_ff ? rd_word[15:0]
                                       : {8'h00, rd_word[7:0]};
                    nxt_olast = (idx_ff == cell_len_ff - 6'd1);
                end else if (cell_ready_i) begin
                    nxt_ovalid = 1'b0;
                    nxt_olast = 1'b0;
                    if (olast_ff) begin
                        nxt_rd_ptr = rd_ptr_ff + (AW+1)'(cell_len_ff);
                        nxt_state = UTXPC_IDLE;
                    end else begin
                        nxt_idx = idx_ff + 6'd1;
                        nxt_state = UTXPC_SEND_RD;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            state_ff <= UTXPC_IDLE;
            idx_ff <= 6'd0;
            cell_len_ff <= UTXPC_CELL_BYTES;
            b16_ff <= 1'b0;
            chk_vld_ff <= 1'b0;
            cell_err_ff <= 1'b0;
            rd_ptr_ff <= '0;
            ovalid_ff <= 1'b0;
            odata_ff <= 16'h0000;
            olast_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            idx_ff <= nxt_idx;
            cell_len_ff <= nxt_cell_len;
            b16_ff <= nxt_b16;
            chk_vld_ff <= nxt_chk_vld;
            cell_err_ff <= nxt_cell_err;
            rd_ptr_ff <= nxt_rd_ptr;
            ovalid_ff <= nxt_ovalid;
            odata_ff <= nxt_odata;
            olast_ff <= nxt_olast;
        end
    end
    assign cell_valid_o = ovalid_ff;
    assign cell_data_o = odata_ff;
    assign cell_last_o = olast_ff;

    // -----------------------------------------------------------------
    // cell fifo storage: word and parity side by side
    // -----------------------------------------------------------------
    utxpc_mem #(
        .W(17),
        .DEPTH(DEPTH)
    ) u_tx_cell_fifo (
        .sys_clk_i(sys_clk_i),
        .wr_en_i(wr_en),
        .wr_addr_i(wr_ptr_ff[AW-1:0]),
        .wr_data_i(sync2_ff[16:0]),
        .rd_addr_i(rd_addr),
        .rd_data_o(rd_word)
    );
endmodule

// [utxpc_checker_props.sv]
module utxpc_checker_props
    import utxpc_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic tx_bus16_mode_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic irq_b_o,
    input wire logic cell_valid_o,
    input wire logic [15:0] cell_data_o,
    input wire logic cell_last_o,
    input wire logic cell_ready_i,
    input wire logic fifo_overflow_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ---------------------------------------------------------------
    // word position within the outgoing cell
    // ---------------------------------------------------------------
    logic [5:0] wcnt_ff; // words taken so far in this cell
    logic [5:0] nxt_wcnt;
    logic [5:0] len_m1; // last index for the current bus mode
    assign len_m1 = (tx_bus16_mode_i ? UTXPC_CELL_WORDS
                                     : UTXPC_CELL_BYTES) - 6'd1;
    // advance on each accepted word, wrap on the last one
    always_comb begin
        nxt_wcnt = wcnt_ff;
        if (cell_valid_o && cell_ready_i) begin
            nxt_wcnt = cell_last_o ? 6'd0 : wcnt_ff + 6'd1;
        end
    end
    // register only
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            wcnt_ff <= 6'd0;
        end else begin
            wcnt_ff <= nxt_wcnt;
        end
    end
    // ---------------------------------------------------------------
    // properties, one clock domain
    // ---------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    rst_quiet_a: assert property ($rose(rst_b_i) |-> irq_b_o
        && !cell_valid_o && reg_rdata_o == 8'h00) else $error("reset");
    word_hold_a: assert property (cell_valid_o && !cell_ready_i
        |=> cell_valid_o && $stable(cell_data_o) && $stable(cell_last_o))
        else $error("word dropped before taken");
    next_word_a: assert property (cell_valid_o && cell_ready_i
        && !cell_last_o |=> !cell_valid_o ##[1:4] cell_valid_o)
        else $error("next word late");
    byte_mode_a: assert property (cell_valid_o && !tx_bus16_mode_i
        |-> cell_data_o[15:8] == 8'h00) else $error("upper byte set");
    cell_len_a: assert property (cell_valid_o && cell_last_o
        |-> wcnt_ff == len_m1) else $error("cell length");
    rdata_keep_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data moved");
    ctrl_ro_a: assert property (reg_rd_i && reg_addr_i == UTXPC_OFF_CTRL0
        |=> reg_rdata_o[2:1] == 2'b00) else $error("ro bits set");
    stat_bits_a: assert property (reg_rd_i && reg_addr_i == UTXPC_OFF_ISTAT
        |=> reg_rdata_o[7:1] == 7'h00) else $error("status bits");
    irq_stick_a: assert property (!irq_b_o && !reg_wr_i && !(reg_rd_i
        && reg_addr_i == UTXPC_OFF_ISTAT) |=> !irq_b_o)
        else $error("interrupt lost");
    ovf_stick_a: assert property (fifo_overflow_o |=> fifo_overflow_o)
        else $error("overflow lost");
    // main scenarios
    last_c: cover property (cell_valid_o && cell_ready_i && cell_last_o);
    irq_c: cover property ($fell(irq_b_o));
    stall_c: cover property (cell_valid_o && !cell_ready_i);
endmodule

bind utxpc_checker utxpc_checker_props i_utxpc_checker_props (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
    .tx_bus16_mode_i(tx_bus16_mode_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .irq_b_o(irq_b_o), .cell_valid_o(cell_valid_o),
    .cell_data_o(cell_data_o), .cell_last_o(cell_last_o),
    .cell_ready_i(cell_ready_i), .fifo_overflow_o(fifo_overflow_o)
);

// [utxpc_atm_src.sv]
// cell source on the far side of the transmit bus
module utxpc_atm_src (
    output logic clk_o,
    output logic [15:0] data_o,
    output logic par_o,
    output logic enb_b_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ---------------------------------------------------------------
    // idle: clock still, bus released
    // ---------------------------------------------------------------
    initial begin
        clk_o = 1'b0;
        data_o = 16'h0000;
        par_o = 1'b0;
        enb_b_o = 1'b1;
    end
    // one whole cell; mask bit k flips the parity of word k
    task automatic send_cell(input logic m16, input logic odd,
                             input logic [15:0] base, input logic [63:0] mask);
        logic [15:0] w;
        int n;
        n = m16 ? 27 : 53;
        // step off the system clock edges so no sample races a change
        #1;
        for (int k = 0; k < n; k++) begin
            // upper lanes carry junk in byte mode on purpose
            w = base + 16'(k) * 16'h0101;
            data_o = w;
            // odd sense: parity bit makes the total count odd
            par_o = (m16 ? ^w : ^w[7:0]) ^ odd ^ mask[k];
            enb_b_o = 1'b0;
            // 32 ns setup and hold around the rising edge
            #32 clk_o = 1'b1;
            #32 clk_o = 1'b0;
        end
        // released lines show the inverse, clock stops
        enb_b_o = 1'b1;
        data_o = ~data_o;
        par_o = ~par_o;
    endtask
endmodule

// [utopia_tx_parity_checker_bench.sv]
module utopia_tx_parity_checker_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import utxpc_pkg::*;
    // ---------------------------------------------------------------
    // stimulus and observation
    // ---------------------------------------------------------------
    logic sys_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic lclk, lpar, lenb_b, mode = 1'b0;
    logic [15:0] ldata;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic wr = 1'b0, rd = 1'b0, irq_b, valid, last, ready = 1'b0, ovf;
    logic [15:0] data;
    logic [1:0] stall_ff = 2'b00; // ready pattern, one stall in four
    logic sink_hold = 1'b0; // holds ready low to back up the fifo
    logic [16:0] got[$]; // {last, data} of every accepted word
    int n_errors = 0;
    int samples_checked = 0;
    always #2 sys_clk_i = ~sys_clk_i;
    utxpc_atm_src i_utxpc_atm_src (.clk_o(lclk), .data_o(ldata),
        .par_o(lpar), .enb_b_o(lenb_b));
    utxpc_checker #(.DEPTH(128)) i_utxpc_checker (.sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i), .tx_interface_clock_i(lclk),
        .tx_cell_data_bus_i(ldata), .tx_word_parity_in_i(lpar),
        .tx_write_enable_b_i(lenb_b), .tx_bus16_mode_i(mode),
        .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_wdata_i(wdata), .reg_rdata_o(rdata), .irq_b_o(irq_b),
        .cell_valid_o(valid), .cell_data_o(data), .cell_last_o(last),
        .cell_ready_i(ready), .fifo_overflow_o(ovf));
    // downstream sink, stalls now and then
    always @(posedge sys_clk_i) begin
        if (valid === 1'b1 && ready === 1'b1) begin
            got.push_back({last, data});
        end
        stall_ff <= stall_ff + 2'd1;
        ready <= (stall_ff != 2'b11) && !sink_hold;
    end
    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task automatic finish_test();
        $display("checked %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("Error at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge sys_clk_i);
        wr <= 1'b0;
    endtask
    // read answer settles one cycle after the read edge
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk_i);
        rd <= 1'b1;
        addr <= a;
        @(posedge sys_clk_i);
        rd <= 1'b0;
        #1 chk({24'h0, rdata}, {24'h0, e});
    endtask
    // count bytes, most significant first (snapshot order)
    task automatic cnt_chk(input logic [31:0] e);
        rd_chk(UTXPC_OFF_CNT3, e[31:24]);
        rd_chk(UTXPC_OFF_CNT2, e[23:16]);
        rd_chk(UTXPC_OFF_CNT1, e[15:8]);
        rd_chk(UTXPC_OFF_CNT0, e[7:0]);
    endtask
    task automatic run_cell(input logic m16, input logic odd,
        input logic [15:0] base, input logic [63:0] mask, input logic fwd);
        int n;
        int i;
        logic [15:0] w;
        n = m16 ? 27 : 53;
        got.delete();
        @(posedge sys_clk_i);
        mode <= m16;
        i_utxpc_atm_src.send_cell(m16, odd, base, mask);
        i = 0;
        while (fwd && got.size() < n && i < 3000) begin
            @(posedge sys_clk_i);
            i++;
        end
        if (i == 3000) begin
            chk(32'h0, 32'h1);
            finish_test();
        end
        if (!fwd) repeat (800) @(posedge sys_clk_i);
        chk(got.size(), fwd ? n : 0);
        for (int k = 0; k < got.size(); k++) begin
            w = base + 16'(k) * 16'h0101;
            if (!m16) w[15:8] = 8'h00;
            chk({15'h0, got[k]}, {15'h0, k == n - 1, w});
        end
    endtask
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_regs();
        rd_chk(UTXPC_OFF_CTRL2, 8'h01);
        rd_chk(UTXPC_OFF_CTRL0, 8'h28);
        rd_chk(UTXPC_OFF_IENA, 8'h01);
        rd_chk(UTXPC_OFF_ISTAT, 8'h00);
        cnt_chk(32'h0);
        wr_reg(8'h02, 8'hFF);
        rd_chk(8'h02, 8'h00);
        wr_reg(UTXPC_OFF_CTRL0, 8'hFF);
        rd_chk(UTXPC_OFF_CTRL0, 8'hF9);
        wr_reg(UTXPC_OFF_CTRL0, 8'h28);
    endtask
    task automatic t_errors();
        run_cell(1'b0, 1'b1, 16'hC312, 64'h0, 1'b1);
        chk(32'(irq_b), 32'h1);
        cnt_chk(32'h0);
        // one bad word kept and reported
        run_cell(1'b1, 1'b1, 16'h1357, 64'h20, 1'b1);
        chk(32'(irq_b), 32'h0);
        rd_chk(UTXPC_OFF_ISTAT, 8'h01);
        rd_chk(UTXPC_OFF_ISTAT, 8'h00);
        chk(32'(irq_b), 32'h1);
        cnt_chk(32'h1);
        // first and last byte bad, masked interrupt, cell dropped
        wr_reg(UTXPC_OFF_IENA, 8'h00);
        wr_reg(UTXPC_OFF_CTRL0, 8'h38);
        run_cell(1'b0, 1'b1, 16'h0F00, 64'h10_0000_0000_0001, 1'b0);
        chk(32'(irq_b), 32'h1);
        rd_chk(UTXPC_OFF_ISTAT, 8'h01);
        cnt_chk(32'h2);
        wr_reg(UTXPC_OFF_IENA, 8'h01);
    endtask
    task automatic t_sense();
        wr_reg(UTXPC_OFF_CTRL0, 8'h20);
        run_cell(1'b1, 1'b0, 16'hA5A5, 64'h0, 1'b1);
        cnt_chk(32'h0);
        // odd source against even check: every word fails
        run_cell(1'b1, 1'b1, 16'h0101, 64'h0, 1'b1);
        cnt_chk(32'h0000001B);
        rd_chk(UTXPC_OFF_ISTAT, 8'h01);
    endtask
    task automatic t_disabled();
        // check off: discard and sense are ignored
        wr_reg(UTXPC_OFF_CTRL0, 8'h10);
        run_cell(1'b0, 1'b1, 16'h7E00, '1, 1'b1);
        cnt_chk(32'h0);
        rd_chk(UTXPC_OFF_ISTAT, 8'h00);
        wr_reg(UTXPC_OFF_CTRL0, 8'h28);
        // processor off: the words never enter
        wr_reg(UTXPC_OFF_CTRL2, 8'h00);
        run_cell(1'b0, 1'b1, 16'h4400, 64'h0, 1'b0);
        wr_reg(UTXPC_OFF_CTRL2, 8'h01);
        rd_chk(UTXPC_OFF_CTRL2, 8'h01);
        chk(32'(ovf), 32'h0);
    endtask
    // sink held off: three cells outgrow the fifo, surplus words are lost
    task automatic t_overflow();
        sink_hold <= 1'b1;
        @(posedge sys_clk_i);
        mode <= 1'b0;
        repeat (3) i_utxpc_atm_src.send_cell(1'b0, 1'b1, 16'h0000, 64'h0);
        repeat (8) @(posedge sys_clk_i);
        chk(32'(ovf), 32'h1);
    endtask
    initial begin
        repeat (8) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        t_regs();
        t_errors();
        t_sense();
        t_disabled();
        t_overflow();
        finish_test();
    end
endmodule
